// ==== inc/pmc_defines.svh ====
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
// Byte offset of the pressure measurement configuration register.
`define PMC_CFG_ADDR 8'h06
// Reset value of the stored fields (bits 6 to 0).
`define PMC_CFG_RESET 7'h00
// Value that the reserved bit 7 always reads as.
`define PMC_RSVD_VAL 1'h0
// Position of the reserved bit.
`define PMC_RSVD_BIT 7
// Field positions inside the register.
`define PMC_RATE_MSB 6
`define PMC_RATE_LSB 4
`define PMC_OS_MSB 3
`define PMC_OS_LSB 0
// Data returned for an offset that this block does not own.
`define PMC_UNOWNED_DATA 8'h00

// ----------------------------------------------------------------------
// Conversion times, in units of 100 us, one per oversampling code
// ----------------------------------------------------------------------
`define PMC_T_OS1 36
`define PMC_T_OS2 52
`define PMC_T_OS4 84
`define PMC_T_OS8 148
`define PMC_T_OS16 276
`define PMC_T_OS32 532
`define PMC_T_OS64 1044
`define PMC_T_OS128 2068
// Number of 100 us units in one second.
`define PMC_UNITS_PER_SEC 10000
// Default clock rate in Hz.
`define PMC_CLK_HZ 20000000

`endif

// ==== inc/pmc_pkg.sv ====
`default_nettype none

// ----------------------------------------------------------------------
// Types shared by the pressure measurement configuration design
// ----------------------------------------------------------------------
package pmc_pkg;

    // Measurement sequencing states.
    typedef enum logic [1:0] {
        PMC_IDLE,
        PMC_SINGLE,
        PMC_BACKGROUND
    } pmc_state_t;

    // State of the top module, apart from the timer and the check counters.
    typedef struct packed {
        logic [6:0] cfg;
        logic [7:0] rdata;
        logic [31:0] rate_cnt;
        logic start;
        logic [31:0] load;
        logic over;
        pmc_state_t st;
    } pmc_top_state_t;

    // Complete state of the conversion timer.
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } pmc_timer_state_t;

endpackage : pmc_pkg

`default_nettype wire

// ==== design/pmc_conv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Conversion timer: stays busy for exactly the loaded number of cycles
// ----------------------------------------------------------------------
module pmc_conv_timer
    import pmc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Start strobe and conversion length in cycles.
    input wire logic start_i,
    input wire logic [31:0] load_i,
    // Conversion status.
    output logic busy_o,
    output logic done_o
);

    pmc_timer_state_t s_reg; // Registered state.
    pmc_timer_state_t s_next; // Next state.

    // A start while busy is dropped, so a conversion is never cut short.
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start_i && !s_reg.busy)
        begin
            // Load the full length; busy then stands for load_i cycles.
            s_next.cnt = load_i;
            s_next.busy = 1'b1;
        end
        else if (s_reg.busy)
        begin
            // Count down and finish on the last cycle of the window.
            s_next.cnt = s_reg.cnt - 32'h1;
            if (s_reg.cnt == 32'h1)
            begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign busy_o = s_reg.busy;
    assign done_o = s_reg.done;

endmodule : pmc_conv_timer

`default_nettype wire

// ==== design/pmc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"

module pmc_top
    import pmc_pkg::*;
#(
    parameter int unsigned CLK_HZ = `PMC_CLK_HZ // Shorten in simulation.
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register access from the serial interface logic.
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Operating mode from the mode control logic.
    input wire logic background_mode_i,
    input wire logic single_req_i,
    // Conversion control towards the measurement path.
    output logic conv_start_o,
    output logic conv_busy_o,
    output logic conv_done_o,
    output logic [2:0] rate_sel_o,
    output logic [3:0] oversample_sel_o,
    output logic budget_over_o
);

    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    // Cycles per 100 us unit, rounded up so no conversion runs short.
    localparam logic [31:0] CYC_PER_UNIT =
        32'((CLK_HZ + `PMC_UNITS_PER_SEC - 1) / `PMC_UNITS_PER_SEC);
    localparam logic [31:0] CYC_PER_SEC = 32'(CLK_HZ); // One second.

    // Conversion length in cycles for an oversampling code.
    function automatic logic [31:0] conv_cycles(input logic [2:0] code);
        logic [31:0] t;
        t = 32'h0;
        unique case (code)
            3'h0: t = 32'(`PMC_T_OS1);
            3'h1: t = 32'(`PMC_T_OS2);
            3'h2: t = 32'(`PMC_T_OS4);
            3'h3: t = 32'(`PMC_T_OS8);
            3'h4: t = 32'(`PMC_T_OS16);
            3'h5: t = 32'(`PMC_T_OS32);
            3'h6: t = 32'(`PMC_T_OS64);
            3'h7: t = 32'(`PMC_T_OS128);
        endcase
        return 32'(t * CYC_PER_UNIT);
    endfunction : conv_cycles

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pmc_top_state_t s_reg; // Registered state.
    pmc_top_state_t s_next; // Next state.
    logic timer_busy; // Conversion in progress.
    logic timer_done; // Conversion finished this cycle.
    logic [2:0] rate; // Current rate code.
    logic [2:0] os_eff; // Oversampling code actually used.
    logic [31:0] period; // Background period in cycles.
    logic launch_ok; // No conversion running or about to start.

    assign rate = s_reg.cfg[`PMC_RATE_MSB:`PMC_RATE_LSB];
    // Codes with bit 3 set are undefined; only the low three bits set the conversion length.
    assign os_eff = s_reg.cfg[`PMC_OS_MSB - 1:`PMC_OS_LSB];
    assign period = CYC_PER_SEC >> rate;
    assign launch_ok = !timer_busy && !s_reg.start;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.start = 1'b0;
        // Register write; bit 7 is dropped so it never stores.
        if (reg_wr_i && reg_addr_i == `PMC_CFG_ADDR)
        begin
            s_next.cfg = reg_wdata_i[`PMC_RATE_MSB:`PMC_OS_LSB];
        end
        // Read data is captured on the strobe and holds until the next one.
        if (reg_rd_i)
        begin
            if (reg_addr_i == `PMC_CFG_ADDR)
            begin
                s_next.rdata = {`PMC_RSVD_VAL, s_reg.cfg};
            end
            else
            begin
                s_next.rdata = `PMC_UNOWNED_DATA;
            end
        end
        // Flags a rate and oversampling pair that exceeds one second.
        s_next.over = ({32'h0, conv_cycles(os_eff)} << rate) >
            {32'h0, CYC_PER_SEC};
        unique case (s_reg.st)
            PMC_IDLE:
            begin
                s_next.rate_cnt = 32'h0;
                if (background_mode_i)
                begin
                    s_next.st = PMC_BACKGROUND;
                end
                else if (single_req_i && launch_ok)
                begin
                    // One conversion, independent of the rate field.
                    s_next.start = 1'b1;
                    s_next.load = conv_cycles(os_eff);
                    s_next.st = PMC_SINGLE;
                end
            end
            PMC_SINGLE:
            begin
                // Wait for the conversion to end before taking new work.
                if (timer_done)
                begin
                    s_next.st = PMC_IDLE;
                end
            end
            PMC_BACKGROUND:
            begin
                if (!background_mode_i)
                begin
                    // A conversion in flight still runs to its end.
                    s_next.st = PMC_IDLE;
                    s_next.rate_cnt = 32'h0;
                end
                else if (s_reg.rate_cnt >= period - 32'h1)
                begin
                    // Period over; a slot that finds the timer busy is
                    // skipped, which is what an over-budget setting costs.
                    s_next.rate_cnt = 32'h0;
                    if (launch_ok)
                    begin
                        s_next.start = 1'b1;
                        s_next.load = conv_cycles(os_eff);
                    end
                end
                else
                begin
                    s_next.rate_cnt = s_reg.rate_cnt + 32'h1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '0;
            s_reg.cfg <= `PMC_CFG_RESET;
            s_reg.st <= PMC_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Conversion timer
    // ------------------------------------------------------------------
    pmc_conv_timer u_pmc_conv_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(s_reg.start),
        .load_i(s_reg.load),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    assign reg_rdata_o = s_reg.rdata;
    assign conv_start_o = s_reg.start;
    assign conv_busy_o = timer_busy;
    assign conv_done_o = timer_done;
    assign rate_sel_o = rate;
    assign oversample_sel_o = s_reg.cfg[`PMC_OS_MSB:`PMC_OS_LSB];
    assign budget_over_o = s_reg.over;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] busy_len; // Length of the current busy window.
    logic [31:0] gap_cnt; // Cycles since the last conversion start.
    logic bg_prev_start; // A background start has been seen.

    // Helper counters read only by the checks below.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_len <= 32'h0;
            gap_cnt <= 32'h0;
            bg_prev_start <= 1'b0;
        end
        else
        begin
            busy_len <= timer_busy ? busy_len + 32'h1 : 32'h0;
            gap_cnt <= conv_start_o ? 32'h1 : gap_cnt + 32'h1;
            if (s_reg.st != PMC_BACKGROUND)
            begin
                bg_prev_start <= 1'b0;
            end
            else if (conv_start_o)
            begin
                bg_prev_start <= 1'b1;
            end
        end
    end

    sequence s_single_take;
        s_reg.st == PMC_IDLE && !background_mode_i && single_req_i && launch_ok;
    endsequence

    sequence s_conv_begin;
        conv_start_o ##1 conv_busy_o;
    endsequence

    a_cfg_write_stores: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == `PMC_CFG_ADDR
            |=> s_reg.cfg == $past(reg_wdata_i[`PMC_RATE_MSB:`PMC_OS_LSB]))
        else $error("Configuration write not stored.");

    a_rsvd_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == `PMC_CFG_ADDR |=> !reg_rdata_o[`PMC_RSVD_BIT]
            && reg_rdata_o[`PMC_RATE_MSB:`PMC_OS_LSB] == $past(s_reg.cfg))
        else $error("Configuration read back wrong.");

    a_single_no_rate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_single_take |=> s_conv_begin)
        else $error("Single request did not start a conversion.");

    a_load_matches_os: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        conv_start_o |-> s_reg.load == conv_cycles($past(os_eff)))
        else $error("Conversion length does not match oversampling.");

    a_conv_duration: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(conv_busy_o) |-> conv_done_o && busy_len == s_reg.load)
        else $error("Conversion busy window has wrong length.");

    a_bg_min_period: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        conv_start_o && bg_prev_start && s_reg.st == PMC_BACKGROUND
            && $stable(rate) |-> gap_cnt >= period)
        else $error("Background conversions closer than the rate period.");

endmodule : pmc_top

`default_nettype wire

// ==== sim/pmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Host model: drives register strobes and mode inputs of the block
// ----------------------------------------------------------------------
module pmc_host_model
(
    // Clock.
    input wire logic sys_clk_i,
    // Read data from the block.
    input wire logic [7:0] reg_rdata_i,
    // Register strobes towards the block.
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    // Mode requests towards the block.
    output logic background_mode_o,
    output logic single_req_o
);
    // Every input of the block is quiet at time zero.
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        background_mode_o = 1'b0;
        single_req_o = 1'b0;
    end

    // One-cycle write strobe; the edge after it releases the strobe.
    // A real host also sets the result shift for 16x and above, which lives elsewhere.
    // No temperature load is run, so the pressure pair alone is the budget.
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        reg_wr_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
    endtask : reg_write

    // Read data is registered, so it is taken just after the take edge.
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk_i);
        reg_addr_o <= addr;
        reg_rd_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        #1;
        data = reg_rdata_i;
    endtask : reg_read

    // Command-triggered conversion request, one cycle long.
    task automatic single_shot();
        @(posedge sys_clk_i);
        single_req_o <= 1'b1;
        @(posedge sys_clk_i);
        single_req_o <= 1'b0;
    endtask : single_shot

    // Background mode is a level that the host holds.
    task automatic set_mode(input logic bg);
        @(posedge sys_clk_i);
        background_mode_o <= bg;
    endtask : set_mode
endmodule : pmc_host_model

`default_nettype wire

// ==== sim/pmc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Self-checking bench for the pressure configuration block
// ----------------------------------------------------------------------
module pmc_top_test;
    import pmc_pkg::*;

    // Clock, reset and block connections.
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr, wdata, rdata, rd;
    logic wr, rd_stb, bg, single, start, busy, done, over;
    logic [2:0] rate;
    logic [3:0] os;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int nb, ns, cnt;
    // Conversion lengths in cycles with one 100 us unit per cycle.
    int conv_len [8] = '{36, 52, 84, 148, 276, 532, 1044, 2068};
    logic [7:0] bud_cfg [4] = '{8'h72, 8'h71, 8'h63, 8'h64};
    logic bud_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    always #25 sys_clk_i = ~sys_clk_i;

    // Simulation CLK_HZ of 10000 makes one second 10000 cycles.
    pmc_top #(.CLK_HZ(10000)) u_pmc_top (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd_stb), .reg_rdata_o(rdata),
        .background_mode_i(bg), .single_req_i(single), .conv_start_o(start),
        .conv_busy_o(busy), .conv_done_o(done), .rate_sel_o(rate),
        .oversample_sel_o(os), .budget_over_o(over));

    pmc_host_model u_pmc_host_model (
        .sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd_stb),
        .background_mode_o(bg), .single_req_o(single));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare with case equality so an unknown never matches.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Counts busy cycles and starts until done, bounded so a hang shows.
    task automatic measure(output int n_busy, output int n_start);
        n_busy = 0;
        n_start = 0;
        for (int i = 0; i < 3000; i++)
        begin
            #1;
            n_busy += (busy === 1'b1) ? 1 : 0;
            n_start += (start === 1'b1) ? 1 : 0;
            if (done === 1'b1)
                break;
            @(posedge sys_clk_i);
        end
    endtask : measure

    // Cycles until the next start pulse; the bound exceeds the period of rate codes 4 to 7.
    task automatic next_start(output int n);
        n = 0;
        for (int i = 0; i < 1500; i++)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (start === 1'b1)
                break;
        end
    endtask : next_start

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // A hang counts as a mismatch; the tests need about 7000 cycles.
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        u_pmc_host_model.reg_read(8'h06, rd);
        check(rd, 8'h00);
        u_pmc_host_model.reg_write(8'h06, 8'hf5);
        u_pmc_host_model.reg_read(8'h06, rd);
        check(rd, 8'h75);
        check(rate, 3'h5 + 3'h2);
        check(os, 4'h5);
        // A neighbouring offset neither changes nor shows this register.
        u_pmc_host_model.reg_write(8'h07, 8'h00);
        u_pmc_host_model.reg_read(8'h07, rd);
        check(rd, 8'h00);
        u_pmc_host_model.reg_read(8'h06, rd);
        check(rd, 8'h75);
        u_pmc_host_model.reg_write(8'h06, 8'h0b);
        repeat (2) @(posedge sys_clk_i);
        check(os, 4'hb);
        // Budget flag on pairs either side of one second.
        for (int i = 0; i < 4; i++)
        begin
            u_pmc_host_model.reg_write(8'h06, bud_cfg[i]);
            repeat (3) @(posedge sys_clk_i);
            #1;
            check(over, bud_exp[i]);
        end
        // Single conversions at every oversampling code with the top rate set.
        for (int k = 0; k < 8; k++)
        begin
            u_pmc_host_model.reg_write(8'h06, {4'h7, k[3:0]});
            // From 16x up the host also sets the result shift at its own
            // offset; this block must leave its register untouched by it.
            if (k >= 4)
                u_pmc_host_model.reg_write(8'h09, 8'h04);
            u_pmc_host_model.single_shot();
            measure(nb, ns);
            check(nb, conv_len[k]);
            check(ns, 1);
            check(done, 1'b1);
        end
        // Background period for the four fastest rates.
        for (int r = 4; r < 8; r++)
        begin
            u_pmc_host_model.reg_write(8'h06, {1'b0, r[2:0], 4'h0});
            u_pmc_host_model.set_mode(1'b1);
            next_start(cnt);
            next_start(cnt);
            check(cnt, 10000 >> r);
            u_pmc_host_model.set_mode(1'b0);
            measure(nb, ns);
            // Leaving background lets the running conversion end, with no new start.
            check(nb, conv_len[0]);
            check(ns, 0);
        end
        print_verdict();
    end
endmodule : pmc_top_test

`default_nettype wire
